// ### verilog/ofb_device.sv
/*
 * Device end of the octal flash bus: decodes frames in 1-1-1 or 8-8-8 mode,
 * single or double rate, tracks bus mode, banks and return strobe.
 * Assumes the link clock comes from the host and is oversampled by mclk_in.
 */
// What this block does
// - four 16 Mbit banks, read other banks
// - single mode 0/3, octal mode 0
// - sample rising, drive falling edge
// - power up in single-line mode
// - deep sleep keeps mode, ultra resets
// - E8h to octal, FFh back, control write
// - volatile octal enable bit selects octal
// - one mode only, octal on eight lines
// - octal opcode one cycle, eight bits after
// - eight dummy cycles, plus half ddr; four in ddr register read
// - auto ultra sleep reverts to single
// - power cycle or reset gives single
// - cs frames operation, outputs released
// - ignore data lines while deselected
// - stay busy until self-timed op ends
// - sdr strobe high while clock low
// - ddr strobe follows clock, ends low
// - rate select bit enables ddr
// - ddr opcode rising, data both edges
// - ddr even bytes, address bit zero cleared
// - ddr register read first edge only
// - octal array read dummies from control byte 3
`default_nettype none
module ofb_device #(
    parameter int BUSY_CYCLES = ofb_pkg::BUSY_CYC,
    parameter logic [7:0] ARRAY_FILL = 8'ha5
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    ofb_link_if.device link,
    input wire logic auto_ultra_sleep_in,
    output logic octal_mode_out,
    output logic ddr_mode_out,
    output logic busy_out,
    output logic standby_out,
    output logic [1:0] busy_bank_out,
    output logic read_refused_out
);
    typedef enum logic [4:0] {
        OFB_IDLE = 5'h01, OFB_CMD = 5'h02, OFB_ADDR = 5'h04, OFB_DUMMY = 5'h08,
        OFB_DATA = 5'h10
    } ofb_phase_t;

    logic [1:0] cs_sync_reg, sck_sync_reg;
    logic [7:0] dq_s1_reg, dq_s2_reg;
    logic sck_prev_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h0;
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
            sck_prev_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
            sck_sync_reg <= {sck_sync_reg[0], link.sclk};
            dq_s1_reg <= link.dq;
            dq_s2_reg <= dq_s1_reg;
            sck_prev_reg <= sck_sync_reg[1];
        end
    end
    wire cs_act = !cs_sync_reg[1];
    wire sck_s = sck_sync_reg[1];
    wire rise = cs_act && sck_s && !sck_prev_reg;
    wire fall = cs_act && !sck_s && sck_prev_reg;
    wire cs_rise = !cs_sync_reg[1] && cs_sync_reg[0];

    ofb_phase_t phase_reg, phase_next;
    logic octal_reg, ddr_reg, busy_reg, sleep_reg, ultra_reg, auto_pend_reg;
    logic [3:0] ctrl3_reg;
    logic [7:0] op_reg, sh_reg, out_reg, ctrl2_reg;
    logic [5:0] cnt_reg;
    logic [31:0] addr_reg;
    logic [1:0] bank_reg;
    logic [15:0] busy_cnt_reg;
    logic strobe_reg, drive_reg, first_reg;

    // in ddr, both edges carry a byte after the opcode; opcode uses rising only
    wire ddr_xfer = ddr_reg && octal_reg && phase_reg != OFB_CMD;
    wire cap = rise || (ddr_xfer && fall);
    wire [7:0] cap_byte = octal_reg ? dq_s2_reg : {sh_reg[6:0], dq_s2_reg[0]};
    wire [5:0] bits_per_byte = octal_reg ? 6'd1 : 6'd8;
    wire byte_done = cap && (cnt_reg + 6'd1 == bits_per_byte);
    wire [5:0] dummy_need = (octal_reg && op_reg == ofb_pkg::OP_READ_ARRAY) ?
        (ddr_reg ? {1'b0, ctrl3_reg, 1'b1} : {2'b00, ctrl3_reg}) :
        (octal_reg ? 6'(2 * ofb_pkg::MIN_DUMMY) : 6'd8);
    wire has_addr = op_reg == ofb_pkg::OP_READ_ARRAY || op_reg == ofb_pkg::OP_PROGRAM ||
        op_reg == ofb_pkg::OP_ERASE_4K;
    wire is_read = op_reg == ofb_pkg::OP_READ_ARRAY || op_reg == ofb_pkg::OP_READ_CTRL;
    wire [31:0] addr_eff = (ddr_reg && octal_reg) ? {addr_reg[31:1], 1'b0} : addr_reg;
    wire [1:0] addr_bank = addr_eff[ofb_pkg::BANK_MSB:ofb_pkg::BANK_LSB];
    wire bank_clash = busy_reg && addr_bank == bank_reg;
    wire [7:0] rd_byte = (op_reg == ofb_pkg::OP_READ_CTRL) ? ctrl2_reg :
        (bank_clash ? 8'hff : ARRAY_FILL);

    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            OFB_IDLE: if (cs_act && !sleep_reg) phase_next = OFB_CMD;
            OFB_CMD: if (byte_done) phase_next = OFB_ADDR;
            OFB_ADDR: if (!has_addr && !is_read) phase_next = OFB_DATA;
                else if (!has_addr) phase_next = OFB_DUMMY;
                else if (byte_done && abytes_reg == 3'(ofb_pkg::ADDR_BYTES - 1))
                    phase_next = is_read ? OFB_DUMMY : OFB_DATA;
            OFB_DUMMY: if (cap && cnt_reg + 6'd1 >= dummy_need) phase_next = OFB_DATA;
            OFB_DATA: phase_next = OFB_DATA;
            default: phase_next = OFB_IDLE;
        endcase
        if (!cs_act) phase_next = OFB_IDLE;
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg <= OFB_IDLE;
            cnt_reg <= 6'd0;
            sh_reg <= 8'h00;
            op_reg <= 8'h00;
            addr_reg <= 32'h0;
            first_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            if (phase_reg != phase_next) cnt_reg <= 6'd0;
            else if (byte_done && phase_reg != OFB_DUMMY) cnt_reg <= 6'd0;
            else if (cap) cnt_reg <= cnt_reg + 6'd1;
            if (cap) sh_reg <= cap_byte;
            if (phase_reg == OFB_CMD && byte_done) op_reg <= cap_byte;
            if (phase_reg == OFB_CMD) first_reg <= 1'b0;
            if (phase_reg == OFB_ADDR && byte_done) begin
                addr_reg <= {addr_reg[23:0], cap_byte};
                first_reg <= 1'b1; // byte count tracked in abytes_reg
            end
            if (phase_reg == OFB_IDLE) addr_reg <= 32'h0;
        end
    end

    // one count per address byte: four bytes mark the end
    logic [2:0] abytes_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) abytes_reg <= 3'd0;
        else if (phase_reg != OFB_ADDR) abytes_reg <= 3'd0;
        else if (byte_done) abytes_reg <= abytes_reg + 3'd1;
    end

    wire frame_end = cs_rise;
    logic ddr_second_reg;
    wire ddr_xfer_second = ddr_second_reg;
    wire ctrl_write = op_reg == ofb_pkg::OP_WRITE_CTRL2 && phase_reg == OFB_DATA &&
        byte_done && !ddr_xfer_second;
    wire self_timed = op_reg == ofb_pkg::OP_PROGRAM || op_reg == ofb_pkg::OP_ERASE_4K;
    wire cmd_taken = frame_end && (phase_reg == OFB_DATA || (phase_reg == OFB_ADDR &&
        abytes_reg == 3'(ofb_pkg::ADDR_BYTES)));

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            octal_reg <= 1'b0;
            ddr_reg <= 1'b0;
            ctrl2_reg <= ofb_pkg::CTRL2_RESET;
            ctrl3_reg <= ofb_pkg::CTRL3_RESET;
            busy_reg <= 1'b0;
            busy_cnt_reg <= 16'h0;
            bank_reg <= 2'd0;
            sleep_reg <= 1'b0;
            ultra_reg <= 1'b0;
            auto_pend_reg <= 1'b0;
            ddr_second_reg <= 1'b0;
        end else begin
            if (phase_reg != OFB_DATA) ddr_second_reg <= 1'b0;
            else if (ddr_xfer && cap) ddr_second_reg <= !ddr_second_reg;
            if (ctrl_write) begin
                ctrl2_reg <= sh_reg == 8'h00 ? cap_byte : cap_byte;
                octal_reg <= cap_byte[ofb_pkg::OCTAL_EN_POS];
                ddr_reg <= cap_byte[ofb_pkg::RATE_SEL_POS];
            end
            if (phase_reg == OFB_ADDR && op_reg == ofb_pkg::OP_ENTER_OCTAL) begin
                octal_reg <= 1'b1;
                ctrl2_reg[ofb_pkg::OCTAL_EN_POS] <= 1'b1;
            end
            if (phase_reg == OFB_ADDR && op_reg == ofb_pkg::OP_EXIT_OCTAL) begin
                octal_reg <= 1'b0;
                ddr_reg <= 1'b0;
                ctrl2_reg <= ofb_pkg::CTRL2_RESET;
            end
            if (frame_end && phase_reg == OFB_DATA && op_reg == ofb_pkg::OP_HW_RESET) begin
                octal_reg <= 1'b0;
                ddr_reg <= 1'b0;
                ctrl2_reg <= ofb_pkg::CTRL2_RESET;
            end
            if (frame_end && phase_reg == OFB_DATA && op_reg == ofb_pkg::OP_DEEP_SLEEP)
                sleep_reg <= 1'b1;
            if (frame_end && phase_reg == OFB_DATA && op_reg == ofb_pkg::OP_ULTRA_SLEEP) begin
                sleep_reg <= 1'b1;
                ultra_reg <= 1'b1;
            end
            if (sleep_reg && cs_act) begin
                sleep_reg <= 1'b0;
                ultra_reg <= 1'b0;
                if (ultra_reg) begin
                    octal_reg <= 1'b0;
                    ddr_reg <= 1'b0;
                    ctrl2_reg <= ofb_pkg::CTRL2_RESET;
                end
            end
            if (cmd_taken && self_timed && !busy_reg) begin
                busy_reg <= 1'b1;
                busy_cnt_reg <= 16'(BUSY_CYCLES);
                bank_reg <= addr_bank;
                auto_pend_reg <= auto_ultra_sleep_in;
            end else if (busy_reg) begin
                if (busy_cnt_reg == 16'h1) busy_reg <= 1'b0;
                busy_cnt_reg <= busy_cnt_reg - 16'h1;
            end
            if (auto_pend_reg && busy_cnt_reg == 16'(BUSY_CYCLES - ofb_pkg::DEEP_SLEEP_CYC)) begin
                auto_pend_reg <= 1'b0;
                octal_reg <= 1'b0;
                ddr_reg <= 1'b0;
                ctrl2_reg <= ofb_pkg::CTRL2_RESET;
                sleep_reg <= 1'b1;
                ultra_reg <= 1'b1;
            end
        end
    end

    // output side: change on falling edge, both edges in ddr; strobe tracks clock in ddr data phase, inverted in sdr
    wire rd_phase = phase_reg == OFB_DATA && is_read;
    wire [7:0] ddr_byte = ddr_second_reg && op_reg == ofb_pkg::OP_READ_CTRL ? 8'h00 : rd_byte;
    // single-line output walks the byte msb first on the so line
    logic [2:0] obit_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_reg <= 8'h00;
            drive_reg <= 1'b0;
            strobe_reg <= 1'b0;
            obit_reg <= 3'd0;
        end else begin
            drive_reg <= rd_phase;
            if (!rd_phase) obit_reg <= 3'd0;
            else if (fall && !octal_reg) obit_reg <= obit_reg + 3'd1;
            if (!rd_phase) strobe_reg <= 1'b0;
            else if (ddr_xfer) strobe_reg <= sck_s;
            else if (fall) strobe_reg <= 1'b1;
            else if (rise) strobe_reg <= 1'b0;
            if (rd_phase && (fall || (ddr_xfer && rise)))
                out_reg <= octal_reg ? ddr_byte : {6'h0, ddr_byte[3'd7 - obit_reg], 1'b0};
        end
    end
    assign link.dev_dq = out_reg;
    assign link.dev_dq_oe = {8{drive_reg && octal_reg}} |
        {6'h00, drive_reg && !octal_reg, 1'b0};
    assign link.return_strobe = strobe_reg;
    assign link.strobe_oe = drive_reg;

    logic [5:0] stat_reg;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) stat_reg <= 6'h10;
        else stat_reg <= {!busy_reg && !cs_act, rd_phase && op_reg == ofb_pkg::OP_READ_ARRAY
            && bank_clash, busy_reg, bank_reg, ddr_reg};
    end
    assign octal_mode_out = octal_reg;
    assign ddr_mode_out = stat_reg[0];
    assign busy_bank_out = stat_reg[2:1];
    assign busy_out = stat_reg[3];
    assign read_refused_out = stat_reg[4];
    assign standby_out = stat_reg[5];
endmodule : ofb_device
`default_nettype wire

// ### verilog/ofb_pkg.sv
/*
 * Shared constants for the octal flash bus interface: opcodes, mode codes,
 * bank layout and timing counts used by both ends.
 * Assumes a 100 MHz system clock on each end and a link clock made by the host.
 */
`default_nettype none
package ofb_pkg;
    localparam int CLK_MHZ = 100;
    localparam logic [7:0] OP_ENTER_OCTAL = 8'he8;
    localparam logic [7:0] OP_EXIT_OCTAL = 8'hff;
    localparam logic [7:0] OP_READ_ARRAY = 8'h0b;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_WRITE_CTRL2 = 8'h71;
    localparam logic [7:0] OP_READ_CTRL = 8'h65;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;
    localparam logic [7:0] OP_HW_RESET = 8'hf0;
    localparam int OCTAL_EN_POS = 3;
    localparam int RATE_SEL_POS = 7;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [3:0] CTRL3_RESET = 4'h8;
    localparam int NUM_BANKS = 4;
    localparam int BANK_MBIT = 16;
    localparam int ADDR_BITS = 23;
    localparam int BANK_MSB = 22;
    localparam int BANK_LSB = 21;
    localparam int ADDR_BYTES = 4;
    localparam int MIN_DUMMY = 4;
    localparam int SCLK_DIV = 4;
    localparam int DEEP_SLEEP_NS = 1000;
    localparam int DEEP_SLEEP_CYC = (DEEP_SLEEP_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_CYC = 200;
endpackage : ofb_pkg
`default_nettype wire

// ### verilog/ofb_link_if.sv
/*
 * Octal flash link: chip select, serial clock, return strobe and eight
 * two-way data lines. Each end drives the data lines with its own enables;
 * the resolved level is worked out here.
 */
`default_nettype none
interface ofb_link_if;
    logic cs_n;
    logic sclk;
    logic return_strobe;
    logic strobe_oe;
    logic [7:0] dev_dq;
    logic [7:0] dev_dq_oe;
    logic [7:0] host_dq;
    logic [7:0] host_dq_oe;
    logic [7:0] dq;
    genvar i;
    for (i = 0; i < 8; i++) begin : g_res
        assign dq[i] = dev_dq_oe[i] ? dev_dq[i] : (host_dq_oe[i] ? host_dq[i] : 1'b1);
    end
    modport device (input cs_n, input sclk, input dq, output return_strobe,
        output strobe_oe, output dev_dq, output dev_dq_oe);
    modport host (output cs_n, output sclk, input dq, input return_strobe,
        input strobe_oe, output host_dq, output host_dq_oe);
endinterface : ofb_link_if
`default_nettype wire

// ### verilog/ofb_host.sv
/*
 * Host end of the octal flash bus: runs one frame per request, making the
 * link clock in mode 0 by dividing mclk_in, sending opcode, address and data.
 * Assumes the device end samples the link clock with its own system clock.
 */
`default_nettype none
module ofb_host #(
    parameter int DIV = ofb_pkg::SCLK_DIV
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    ofb_link_if.host link,
    input wire logic req_in,
    input wire logic [7:0] op_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] addr_bytes_in,
    input wire logic [5:0] dummy_in,
    input wire logic [7:0] wdata_in,
    input wire logic [3:0] data_len_in,
    input wire logic rd_in,
    input wire logic octal_in,
    input wire logic ddr_in,
    output logic busy_out,
    output logic [7:0] rdata_out,
    output logic rvalid_out
);
    typedef enum logic [2:0] {OFH_IDLE = 3'h1, OFH_RUN = 3'h2, OFH_END = 3'h4} ofh_state_t;
    ofh_state_t st_reg;
    logic cs_reg, sck_reg, oe_reg, rv_reg;
    logic [7:0] dq_reg, rd_reg;
    logic [7:0] div_reg;
    logic [8:0] bit_reg, total_reg;
    logic [63:0] sh_reg;
    logic [1:0] st_s_reg;
    logic st_prev_reg;
    logic fresh_reg;
    logic [2:0] rbit_reg;
    wire tick = div_reg == 8'(DIV / 2 - 1);
    wire [8:0] step = octal_in ? 9'd8 : 9'd1;
    wire [8:0] cmd_bits = 9'd8;
    wire [8:0] hdr_bits = cmd_bits + 9'(addr_bytes_in) * 9'd8;
    wire in_hdr = bit_reg < hdr_bits;
    wire in_dummy = !in_hdr && bit_reg < hdr_bits + 9'(dummy_in) * step;
    wire both = ddr_in && octal_in && bit_reg > cmd_bits;
    // unit most recently put on the bus; the device answers it one edge later
    wire [8:0] cur = bit_reg - step;
    wire cur_data = cur >= hdr_bits + 9'(dummy_in) * step;
    // address bytes that are not sent are dropped so data follows at once
    wire [55:0] tail = {addr_in, wdata_in, wdata_in, wdata_in} <<
        (7'd32 - {addr_bytes_in, 3'b000});
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_s_reg <= 2'b00;
            st_prev_reg <= 1'b0;
        end else begin
            st_s_reg <= {st_s_reg[0], link.return_strobe};
            st_prev_reg <= st_s_reg[1];
        end
    end
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg <= OFH_IDLE;
            cs_reg <= 1'b1;
            sck_reg <= 1'b0;
            oe_reg <= 1'b0;
            dq_reg <= 8'h00;
            div_reg <= 8'h0;
            bit_reg <= 9'd0;
            total_reg <= 9'd0;
            sh_reg <= 64'h0;
            rd_reg <= 8'h00;
            rv_reg <= 1'b0;
            fresh_reg <= 1'b0;
            rbit_reg <= 3'd0;
        end else begin
            rv_reg <= 1'b0;
            div_reg <= tick ? 8'h0 : div_reg + 8'h1;
            case (st_reg)
                OFH_IDLE: if (req_in) begin
                    st_reg <= OFH_RUN;
                    cs_reg <= 1'b0;
                    sh_reg <= octal_in ? {tail, 8'h00} : {op_in[6:0], tail, 1'b0};
                    dq_reg <= octal_in ? op_in : {7'h0, op_in[7]};
                    oe_reg <= 1'b1;
                    fresh_reg <= 1'b1;
                    rbit_reg <= 3'd0;
                    bit_reg <= step;
                    total_reg <= hdr_bits + 9'(dummy_in) * step + 9'(data_len_in) * 9'd8;
                    div_reg <= 8'h0;
                end
                OFH_RUN: if (tick) begin
                    sck_reg <= !sck_reg;
                    if ((!sck_reg || both) && fresh_reg && rd_in && cur_data) begin
                        if (octal_in) begin
                            rd_reg <= link.dq;
                            rv_reg <= 1'b1;
                        end else begin
                            rd_reg <= {rd_reg[6:0], link.dq[1]};
                            rbit_reg <= rbit_reg + 3'd1;
                            rv_reg <= rbit_reg == 3'd7;
                        end
                    end
                    if (!sck_reg || both) fresh_reg <= 1'b0;
                    if (sck_reg && bit_reg >= total_reg) begin
                        st_reg <= OFH_END;
                    end
                    if (sck_reg == 1'b1 || both) begin
                        if (bit_reg < total_reg) begin
                            fresh_reg <= 1'b1;
                            oe_reg <= in_hdr || (!in_dummy && !rd_in);
                            dq_reg <= octal_in ? sh_reg[63:56] : {7'h0, sh_reg[63]};
                            sh_reg <= octal_in ? {sh_reg[55:0], 8'h00} : {sh_reg[62:0], 1'b0};
                            bit_reg <= bit_reg + step;
                        end
                    end
                end
                OFH_END: begin
                    cs_reg <= 1'b1;
                    oe_reg <= 1'b0;
                    sck_reg <= 1'b0;
                    st_reg <= OFH_IDLE;
                end
                default: st_reg <= OFH_IDLE;
            endcase
            if (st_reg == OFH_IDLE && !req_in) begin
                oe_reg <= 1'b0;
            end
        end
    end
    assign link.cs_n = cs_reg;
    assign link.sclk = sck_reg;
    assign link.host_dq = dq_reg;
    assign link.host_dq_oe = octal_in ? {8{oe_reg}} : {7'h0, oe_reg};
    assign busy_out = st_reg != OFH_IDLE;
    assign rdata_out = rd_reg;
    assign rvalid_out = rv_reg;
endmodule : ofb_host
`default_nettype wire

// ### sim/ofb_link_assertions.sv
/* Checker for the octal flash link between host and device ends.
   Assumes the host makes sclk by dividing mclk_in by DIV, in mode 0. */
`default_nettype none
module ofb_link_assertions #(
    parameter int DIV = 4
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic strobe_oe,
    input wire logic [7:0] dev_dq_oe,
    input wire logic [7:0] host_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts mclk cycles that sclk has stood high
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    assign hi_next = sclk ? hi_reg + 8'h01 : 8'h00;
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hi_reg <= 8'h00;
        end else begin
            hi_reg <= hi_next;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // deselect seen long enough to pass the device's synchronisers
    sequence idle_s;
        cs_n [*6];
    endsequence
    dev_release_a: assert property (idle_s |-> dev_dq_oe == 8'h00)
        else $error("device drives data lines while deselected");
    strobe_release_a: assert property (idle_s |-> !strobe_oe)
        else $error("device drives strobe while deselected");
    host_release_a: assert property (cs_n [*3] |-> host_dq_oe == 8'h00)
        else $error("host drives data lines outside a frame");
    one_driver_a: assert property ((dev_dq_oe & host_dq_oe) == 8'h00)
        else $error("both ends drive one data line");
    sclk_idle_a: assert property (cs_n [*2] |-> !sclk)
        else $error("link clock not low while idle");
    frame_start_a: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
        else $error("frame opened with link clock high");
    sclk_framed_a: assert property ($rose(sclk) |-> !cs_n)
        else $error("link clock pulse outside a frame");
    sclk_half_a: assert property ($fell(sclk) |-> hi_reg == 8'(DIV / 2))
        else $error("link clock high phase has wrong length");
endmodule : ofb_link_assertions
`default_nettype wire

// ### sim/testbench.sv
/* Self-checking bench: host and device ends joined by the link, with a
   model of bus mode, busy bank and read data. Assumes package and interface. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY = 2000;
    // link clock of 80 ns leaves the device's synchronisers time to answer
    localparam int HDIV = 8;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic req = 1'b0;
    logic rd = 1'b0;
    logic oct = 1'b0;
    logic ddr = 1'b0;
    logic auto_sleep = 1'b0;
    logic [7:0] op = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [31:0] addr = 32'h0;
    logic [3:0] nab = 4'h0;
    logic [3:0] len = 4'h0;
    logic [5:0] dum = 6'h0;
    logic [7:0] rdata;
    logic hbusy, rvalid, m_oct, m_ddr, dbusy, stby, refused;
    logic saw_ref = 1'b0;
    logic [1:0] bank;
    logic [7:0] got[$];
    int failures = 0;
    int checked = 0;
    int seed = 89;
    int e_oct = 0;
    int e_ddr = 0;
    int e_busy = 0;
    int pbank = 0;
    ofb_link_if link ();
    ofb_device #(.BUSY_CYCLES(BUSY)) u_ofb_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .link(link.device), .auto_ultra_sleep_in(auto_sleep), .octal_mode_out(m_oct),
        .ddr_mode_out(m_ddr), .busy_out(dbusy), .standby_out(stby), .busy_bank_out(bank),
        .read_refused_out(refused));
    ofb_host #(.DIV(HDIV)) u_ofb_host (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
        .link(link.host),
        .req_in(req), .op_in(op), .addr_in(addr), .addr_bytes_in(nab), .dummy_in(dum),
        .wdata_in(wdata), .data_len_in(len), .rd_in(rd), .octal_in(oct), .ddr_in(ddr),
        .busy_out(hbusy), .rdata_out(rdata), .rvalid_out(rvalid));
    ofb_link_assertions #(.DIV(HDIV)) u_ofb_link_assertions (.mclk_in(mclk_in),
        .arst_n_in(arst_n_in), .cs_n(link.cs_n), .sclk(link.sclk),
        .strobe_oe(link.strobe_oe), .dev_dq_oe(link.dev_dq_oe), .host_dq_oe(link.host_dq_oe));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (rvalid === 1'b1) got.push_back(rdata);
        if (refused === 1'b1) saw_ref <= 1'b1;
    end
    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one host frame; inputs held until the host reports busy
    task automatic frame(input logic [7:0] o, input int n_a, input int n_d, input logic r);
        int t;
        got.delete();
        @(posedge mclk_in);
        saw_ref <= 1'b0;
        op <= o;
        nab <= 4'(n_a);
        len <= 4'(n_d);
        rd <= r;
        // ddr counts dummies in half cycles: eight and a half cycles
        dum <= r ? ((e_oct != 0 && e_ddr != 0) ? 6'h11 : 6'h08) : 6'h00;
        oct <= (e_oct != 0);
        ddr <= (e_oct != 0 && e_ddr != 0);
        req <= 1'b1;
        t = 0;
        do @(posedge mclk_in); while (hbusy !== 1'b1 && ++t < 100);
        req <= 1'b0;
        do @(posedge mclk_in); while (hbusy !== 1'b0 && ++t < 4000);
        if (t >= 4000) failures++;
        repeat (8) @(posedge mclk_in);
    endtask : frame
    task automatic rd_chk(input int bk, input int n);
        logic [7:0] e;
        addr <= {9'h0, 2'(bk), 21'($random(seed))};
        frame(ofb_pkg::OP_READ_ARRAY, 4, n, 1'b1);
        e = (e_busy != 0 && bk == pbank) ? 8'hff : 8'ha5;
        chk(8'(got.size()), 8'(n));
        foreach (got[i]) chk(got[i], e);
        chk({7'h0, saw_ref}, {7'h0, e == 8'hff});
    endtask : rd_chk
    task automatic wait_idle();
        int t;
        t = 0;
        while (dbusy !== 1'b0 && t < BUSY + 500) begin
            @(posedge mclk_in);
            t++;
        end
        repeat (ofb_pkg::DEEP_SLEEP_CYC + 10) @(posedge mclk_in);
        e_busy = 0;
    endtask : wait_idle
    task automatic ctrl2(input logic [7:0] v);
        wdata <= v;
        frame(ofb_pkg::OP_WRITE_CTRL2, 0, 1, 1'b0);
        e_oct = v[ofb_pkg::OCTAL_EN_POS];
        e_ddr = v[ofb_pkg::RATE_SEL_POS];
    endtask : ctrl2
    initial begin
        repeat (4) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        @(posedge mclk_in);
        chk({7'h0, m_oct}, 8'h00);
        rd_chk($random(seed) & 3, 2);
        frame(ofb_pkg::OP_ENTER_OCTAL, 0, 0, 1'b0);
        e_oct = 1;
        chk({7'h0, m_oct}, 8'(e_oct));
        rd_chk($random(seed) & 3, 4);
        frame(ofb_pkg::OP_DEEP_SLEEP, 0, 0, 1'b0);
        frame(8'h00, 0, 0, 1'b0);
        chk({7'h0, m_oct}, 8'(e_oct));
        ctrl2(8'h88);
        chk({7'h0, m_ddr}, 8'(e_ddr));
        rd_chk($random(seed) & 3, 2);
        pbank = $random(seed) & 3;
        addr <= {9'h0, 2'(pbank), 21'($random(seed)) | 21'h1};
        wdata <= 8'($random(seed));
        frame(ofb_pkg::OP_PROGRAM, 4, 2, 1'b0);
        e_busy = 1;
        chk({dbusy, stby, 4'h0, bank}, {2'b10, 4'h0, 2'(pbank)});
        rd_chk(pbank, 2);
        rd_chk((pbank + 1) % 4, 2);
        wait_idle();
        chk({7'h0, stby}, 8'h01);
        frame(ofb_pkg::OP_EXIT_OCTAL, 0, 0, 1'b0);
        e_oct = 0;
        chk({7'h0, m_oct}, 8'h00);
        ctrl2(8'h08);
        chk({7'h0, m_oct}, 8'h01);
        frame(ofb_pkg::OP_HW_RESET, 0, 0, 1'b0);
        e_oct = 0;
        chk({7'h0, m_oct}, 8'h00);
        ctrl2(8'h08);
        auto_sleep <= 1'b1;
        addr <= {9'h0, 23'($random(seed))};
        frame(ofb_pkg::OP_ERASE_4K, 4, 0, 1'b0);
        wait_idle();
        e_oct = 0;
        chk({7'h0, m_oct}, 8'h00);
        auto_sleep <= 1'b0;
        frame(8'h00, 0, 0, 1'b0);
        frame(ofb_pkg::OP_ENTER_OCTAL, 0, 0, 1'b0);
        e_oct = 1;
        frame(ofb_pkg::OP_ULTRA_SLEEP, 0, 0, 1'b0);
        frame(8'h00, 0, 0, 1'b0);
        chk({7'h0, m_oct}, 8'h00);
        finish_test();
    end
    initial begin
        #800us;
        failures++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
